/* File: dcr_pkg.sv */
`default_nettype none
package dcr_pkg;
   // clock period
   localparam int CLK_PERIOD_NS       = 10;
   // pin group widths
   localparam int GPIO_WIDTH          = 20;
   localparam int TEST_WIDTH          = 8;
   // test pin sample point after release, in its own unit
   localparam int TEST_SAMPLE_NS      = 1500;
   localparam int TEST_SAMPLE_CYCLES  = (TEST_SAMPLE_NS / CLK_PERIOD_NS < 1) ? 1
                                        : TEST_SAMPLE_NS / CLK_PERIOD_NS;
   // host two-wire quiet time after release, in its own unit
   localparam int I2C_QUIET_MS        = 500;
   localparam int I2C_QUIET_CYCLES    = (I2C_QUIET_MS * 1000000) / CLK_PERIOD_NS;
   // synchroniser reset levels
   localparam logic POC_SYNC_RESET    = 1'b0;
   localparam logic PARK_SYNC_RESET   = 1'b0;
   // sequencer states
   typedef enum logic [1:0] {ST_HELD, ST_SAMPLE, ST_RUN} dcr_state_type;
endpackage
`default_nettype wire

/* File: dcr_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module dcr_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // clock, reset, enable
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   // asynchronous level in, synchronous level out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_q   <= RESET_VAL;
         sync_out <= RESET_VAL;
      end
      else if (ce)
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

/* File: dcr_reset_entry.sv */
`timescale 1ns/1ps
`default_nettype none
module dcr_reset_entry #(
   parameter int QUIET_CYCLES = dcr_pkg::I2C_QUIET_CYCLES
) (
   // clock, reset, enable
   input  wire logic                            MCLK,
   input  wire logic                            RST,
   input  wire logic                            CE,
   // reset and park pins, asynchronous
   input  wire logic                            POWER_ON_CLEAR_N,
   input  wire logic                            FAST_MIRROR_STOP_N,
   // functional values from the configured core
   input  wire logic                            FUNC_FLASH_SERIAL_CLOCK,
   input  wire logic                            FUNC_FLASH_SERIAL_DATA_OUT,
   input  wire logic                            FUNC_FLASH_CHIP_SELECT0_N,
   input  wire logic                            FUNC_FLASH_CHIP_SELECT1_N,
   input  wire logic [dcr_pkg::GPIO_WIDTH-1:0]  FUNC_GPIO_OUT,
   input  wire logic [dcr_pkg::GPIO_WIDTH-1:0]  FUNC_GPIO_OE,
   input  wire logic                            FUNC_LIGHT_SOURCE_SELECT0,
   input  wire logic                            FUNC_LIGHT_SOURCE_SELECT1,
   input  wire logic                            FUNC_MIRROR_ARRAY_DRIVE_ENABLE_N,
   input  wire logic [dcr_pkg::TEST_WIDTH-1:0]  FUNC_TEST_OUT,
   // flash port pins
   output logic                                 FLASH_SERIAL_CLOCK_O,
   output logic                                 FLASH_SERIAL_DATA_OUT_O,
   output logic                                 FLASH_CHIP_SELECT0_N_O,
   output logic                                 FLASH_CHIP_SELECT1_N_O,
   output logic                                 FLASH_OE,
   // general-purpose pins
   input  wire logic [dcr_pkg::GPIO_WIDTH-1:0]  GPIO_I,
   output logic      [dcr_pkg::GPIO_WIDTH-1:0]  GPIO_O,
   output logic      [dcr_pkg::GPIO_WIDTH-1:0]  GPIO_OE,
   output logic      [dcr_pkg::GPIO_WIDTH-1:0]  GPIO_IN_SYNC,
   // light source and mirror drive pins
   output logic                                 LIGHT_SOURCE_SELECT0,
   output logic                                 LIGHT_SOURCE_SELECT1,
   output logic                                 MIRROR_ARRAY_DRIVE_ENABLE_N,
   // test point pins
   input  wire logic [dcr_pkg::TEST_WIDTH-1:0]  TEST_POINT_PINS_I,
   output logic      [dcr_pkg::TEST_WIDTH-1:0]  TEST_POINT_PINS_O,
   output logic      [dcr_pkg::TEST_WIDTH-1:0]  TEST_POINT_PINS_OE,
   // status to the core
   output logic      [dcr_pkg::TEST_WIDTH-1:0]  TEST_MODE_SELECT,
   output logic                                 CONFIG_START,
   output logic                                 CONFIG_ACTIVE,
   output logic                                 I2C_QUIET_DONE
);
   localparam int SMP_W = $clog2(dcr_pkg::TEST_SAMPLE_CYCLES + 1);
   localparam int QT_W  = $clog2(QUIET_CYCLES + 1);
   localparam logic [SMP_W-1:0] SMP_LAST = SMP_W'(dcr_pkg::TEST_SAMPLE_CYCLES - 1);
   localparam logic [QT_W-1:0]  QT_LAST  = QT_W'(QUIET_CYCLES - 1);
   // refuse counts the counters cannot serve
   if (QUIET_CYCLES < 1)
      $error("QUIET_CYCLES must be at least one");
   dcr_pkg::dcr_state_type       st_q;
   dcr_pkg::dcr_state_type       st_d;
   logic                         poc_s;
   logic                         park_s;
   logic                         poc_prev_q;
   logic                         poc_rise;
   logic [SMP_W-1:0]             smp_cnt_q;
   logic [QT_W-1:0]              qt_cnt_q;
   logic [dcr_pkg::TEST_WIDTH-1:0] test_s;

   // clear and park pins cross into MCLK before anything reads them
   dcr_sync #(.WIDTH(1), .RESET_VAL(dcr_pkg::POC_SYNC_RESET)) u_poc_sync (
      .clk      (MCLK),
      .rst      (RST),
      .ce       (CE),
      .async_in (POWER_ON_CLEAR_N),
      .sync_out (poc_s)
   );
   dcr_sync #(.WIDTH(1), .RESET_VAL(dcr_pkg::PARK_SYNC_RESET)) u_park_sync (
      .clk      (MCLK),
      .rst      (RST),
      .ce       (CE),
      .async_in (FAST_MIRROR_STOP_N),
      .sync_out (park_s)
   );
   dcr_sync #(.WIDTH(dcr_pkg::TEST_WIDTH), .RESET_VAL('0)) u_test_sync (
      .clk      (MCLK),
      .rst      (RST),
      .ce       (CE),
      .async_in (TEST_POINT_PINS_I),
      .sync_out (test_s)
   );
   dcr_sync #(.WIDTH(dcr_pkg::GPIO_WIDTH), .RESET_VAL('0)) u_gpio_sync (
      .clk      (MCLK),
      .rst      (RST),
      .ce       (CE),
      .async_in (GPIO_I),
      .sync_out (GPIO_IN_SYNC)
   );
   // release edge seen on the synchronised level only
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
         poc_prev_q <= 1'b0;
      else if (CE)
         poc_prev_q <= poc_s;
   end
   assign poc_rise = poc_s & ~poc_prev_q;
   // sequencer: any clear level drops straight back to held
   always_comb
   begin
      st_d = st_q;
      if (!poc_s)
         st_d = dcr_pkg::ST_HELD;
      else
         unique case (st_q)
            dcr_pkg::ST_HELD:   if (poc_rise) st_d = dcr_pkg::ST_SAMPLE;
            dcr_pkg::ST_SAMPLE: if (smp_cnt_q == SMP_LAST) st_d = dcr_pkg::ST_RUN;
            dcr_pkg::ST_RUN:    st_d = dcr_pkg::ST_RUN;
         endcase
   end

   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
         st_q <= dcr_pkg::ST_HELD;
      else if (CE)
         st_q <= st_d;
   end

   // sample delay counter, runs only between release and test sampling
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
         smp_cnt_q <= '0;
      else if (CE)
      begin
         if (st_q == dcr_pkg::ST_SAMPLE && poc_s)
            smp_cnt_q <= smp_cnt_q + SMP_W'(1);
         else
            smp_cnt_q <= '0;
      end
   end

   // test mode select captured once, at the end of the sample delay
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
         TEST_MODE_SELECT <= '0;
      else if (CE)
      begin
         if (!poc_s)
            TEST_MODE_SELECT <= '0;
         else if (st_q == dcr_pkg::ST_SAMPLE && smp_cnt_q == SMP_LAST)
            TEST_MODE_SELECT <= test_s;
      end
   end

   // configuration start pulse and busy level
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         CONFIG_START  <= 1'b0;
         CONFIG_ACTIVE <= 1'b0;
      end
      else if (CE)
      begin
         CONFIG_START  <= (st_q == dcr_pkg::ST_HELD) && poc_rise;
         CONFIG_ACTIVE <= (st_d != dcr_pkg::ST_HELD);
      end
   end

   // quiet timer: informs the core when host traffic may be expected
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         qt_cnt_q       <= '0;
         I2C_QUIET_DONE <= 1'b0;
      end
      else if (CE)
      begin
         if (!poc_s || !park_s)
         begin
            qt_cnt_q       <= '0;
            I2C_QUIET_DONE <= 1'b0;
         end
         else if (qt_cnt_q == QT_LAST)
            I2C_QUIET_DONE <= 1'b1;
         else
            qt_cnt_q <= qt_cnt_q + QT_W'(1);
      end
   end

   // pin drive registered; held state floats or forces low
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         FLASH_SERIAL_CLOCK_O        <= 1'b0;
         FLASH_SERIAL_DATA_OUT_O     <= 1'b0;
         FLASH_CHIP_SELECT0_N_O      <= 1'b1;
         FLASH_CHIP_SELECT1_N_O      <= 1'b1;
         FLASH_OE                    <= 1'b0;
         GPIO_O                      <= '0;
         GPIO_OE                     <= '0;
         LIGHT_SOURCE_SELECT0        <= 1'b0;
         LIGHT_SOURCE_SELECT1        <= 1'b0;
         MIRROR_ARRAY_DRIVE_ENABLE_N <= 1'b0;
         TEST_POINT_PINS_O           <= '0;
         TEST_POINT_PINS_OE          <= '0;
      end
      else if (CE)
      begin
         if (st_d == dcr_pkg::ST_HELD)
         begin
            FLASH_CHIP_SELECT0_N_O      <= 1'b1;
            FLASH_CHIP_SELECT1_N_O      <= 1'b1;
            FLASH_OE                    <= 1'b0;
            GPIO_OE                     <= '0;
            LIGHT_SOURCE_SELECT0        <= 1'b0;
            LIGHT_SOURCE_SELECT1        <= 1'b0;
            MIRROR_ARRAY_DRIVE_ENABLE_N <= 1'b0;
            TEST_POINT_PINS_OE          <= '0;
         end
         else
         begin
            // flash and gpio run as soon as configuration begins
            FLASH_SERIAL_CLOCK_O        <= FUNC_FLASH_SERIAL_CLOCK;
            FLASH_SERIAL_DATA_OUT_O     <= FUNC_FLASH_SERIAL_DATA_OUT;
            FLASH_CHIP_SELECT0_N_O      <= FUNC_FLASH_CHIP_SELECT0_N;
            FLASH_CHIP_SELECT1_N_O      <= FUNC_FLASH_CHIP_SELECT1_N;
            FLASH_OE                    <= 1'b1;
            GPIO_O                      <= FUNC_GPIO_OUT;
            GPIO_OE                     <= FUNC_GPIO_OE;
            LIGHT_SOURCE_SELECT0        <= FUNC_LIGHT_SOURCE_SELECT0;
            LIGHT_SOURCE_SELECT1        <= FUNC_LIGHT_SOURCE_SELECT1;
            MIRROR_ARRAY_DRIVE_ENABLE_N <= FUNC_MIRROR_ARRAY_DRIVE_ENABLE_N;
            // test pins stay inputs until sampled
            TEST_POINT_PINS_O           <= FUNC_TEST_OUT;
            TEST_POINT_PINS_OE          <= {dcr_pkg::TEST_WIDTH{st_d == dcr_pkg::ST_RUN}};
         end
      end
   end

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   sequence s_release;
      CE && st_q == dcr_pkg::ST_HELD && poc_rise;
   endsequence
   sequence s_sample_end;
      CE && st_q == dcr_pkg::ST_SAMPLE && poc_s && smp_cnt_q == SMP_LAST;
   endsequence
   property p_start;
      s_release |=> CONFIG_START && st_q == dcr_pkg::ST_SAMPLE;
   endproperty
   a_start: assert property (p_start) else $error("release did not start config");
   property p_float;
      (CE && !poc_s) |=> !FLASH_OE && GPIO_OE == '0;
   endproperty
   a_float: assert property (p_float) else $error("flash or gpio driven in clear");
   property p_low;
      (CE && !poc_s) |=> !LIGHT_SOURCE_SELECT0 && !LIGHT_SOURCE_SELECT1
                         && !MIRROR_ARRAY_DRIVE_ENABLE_N;
   endproperty
   a_low: assert property (p_low) else $error("light or mirror not low in clear");
   property p_quiet_in_clear;
      (CE && !poc_s) |=> !CONFIG_ACTIVE && !CONFIG_START && !I2C_QUIET_DONE;
   endproperty
   a_quiet_in_clear: assert property (p_quiet_in_clear) else $error("active output in clear");
   property p_gpio_out;
      (CE && poc_s && st_q != dcr_pkg::ST_HELD) |=> GPIO_OE == $past(FUNC_GPIO_OE);
   endproperty
   a_gpio_out: assert property (p_gpio_out) else $error("gpio enable not passed");
   property p_test_sample;
      s_sample_end |=> TEST_MODE_SELECT == $past(test_s) && TEST_POINT_PINS_OE == '1;
   endproperty
   a_test_sample: assert property (p_test_sample) else $error("test pins not sampled");
   property p_test_float;
      (st_q != dcr_pkg::ST_RUN) |-> TEST_POINT_PINS_OE == '0
         || ($past(st_q) == dcr_pkg::ST_SAMPLE && $past(smp_cnt_q) == SMP_LAST);
   endproperty
   a_test_float: assert property (p_test_float) else $error("test pins driven early");
   property p_sync_hold;
      (st_q == dcr_pkg::ST_HELD && !poc_s) |=> st_q == dcr_pkg::ST_HELD;
   endproperty
   a_sync_hold: assert property (p_sync_hold) else $error("left held without release");
   // levels judged at the edge that set the flag, a clear may follow at once
   property p_quiet_time;
      $rose(I2C_QUIET_DONE) |-> $past(qt_cnt_q) == QT_LAST && $past(poc_s) && $past(park_s);
   endproperty
   a_quiet_time: assert property (p_quiet_time) else $error("quiet done early");
endmodule
`default_nettype wire

/* File: dcr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dcr_host_model (
   // clock and bench commands
   input  wire logic                           clk,
   input  wire logic                           go,
   input  wire logic                           park_late,
   input  wire logic [dcr_pkg::TEST_WIDTH-1:0] strap,
   // reset and park pins toward the device
   output logic                                poc_n,
   output logic                                park_n,
   // test point pins, weakly strapped on the board
   input  wire logic [dcr_pkg::TEST_WIDTH-1:0] test_o,
   input  wire logic [dcr_pkg::TEST_WIDTH-1:0] test_oe,
   output logic      [dcr_pkg::TEST_WIDTH-1:0] test_pin
);
   int unsigned cnt   = 0;
   logic        poc_q = 1'b0;
   logic        prk_q = 1'b1;
   // supplies need a few cycles to settle, so clear lets go late
   always @(negedge clk)
   begin
      if (!go)
      begin
         cnt   <= 0;
         poc_q <= 1'b0;
         prk_q <= !park_late;
      end
      else
      begin
         cnt   <= cnt + 1;
         poc_q <= (cnt >= 4);
         prk_q <= !park_late || (cnt >= 30);
      end
   end
   // park normally high first; late park only when the bench asks
   assign poc_n  = poc_q;
   assign park_n = prk_q;
   // undriven pins settle to the strap level, never hold old data
   assign test_pin = (test_o & test_oe) | (strap & ~test_oe);
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
   $display("BAD %0t %s", $time, m); end end
module tb_top;
   localparam int QUIET = 20;
   localparam int GW    = dcr_pkg::GPIO_WIDTH;
   localparam int TW    = dcr_pkg::TEST_WIDTH;
   logic          clk, rst, go, park_late, poc_n, park_n, ce, ce_plan;
   logic          f_sck, f_sdo, f_cs0, f_cs1, f_l0, f_l1, f_men;
   logic          sck, sdo, cs0, cs1, foe, l0, l1, men, cfg_start, cfg_act, qdone;
   logic [GW-1:0] f_gout, f_goe, gpio_i, gp_o, gp_oe, g_sync, g1, g2;
   logic [TW-1:0] strap, f_tout, t_pin, t_o, t_oe, tms;
   logic [3:0]    hist;
   logic [2:0]    ph;
   int            bad_count, tests_run, seed, k, bc;

   dcr_reset_entry #(.QUIET_CYCLES(QUIET)) u_dut (
      .MCLK(clk), .RST(rst), .CE(ce),
      .POWER_ON_CLEAR_N(poc_n), .FAST_MIRROR_STOP_N(park_n),
      .FUNC_FLASH_SERIAL_CLOCK(f_sck), .FUNC_FLASH_SERIAL_DATA_OUT(f_sdo),
      .FUNC_FLASH_CHIP_SELECT0_N(f_cs0), .FUNC_FLASH_CHIP_SELECT1_N(f_cs1),
      .FUNC_GPIO_OUT(f_gout), .FUNC_GPIO_OE(f_goe),
      .FUNC_LIGHT_SOURCE_SELECT0(f_l0), .FUNC_LIGHT_SOURCE_SELECT1(f_l1),
      .FUNC_MIRROR_ARRAY_DRIVE_ENABLE_N(f_men), .FUNC_TEST_OUT(f_tout),
      .FLASH_SERIAL_CLOCK_O(sck), .FLASH_SERIAL_DATA_OUT_O(sdo),
      .FLASH_CHIP_SELECT0_N_O(cs0), .FLASH_CHIP_SELECT1_N_O(cs1), .FLASH_OE(foe),
      .GPIO_I(gpio_i), .GPIO_O(gp_o), .GPIO_OE(gp_oe), .GPIO_IN_SYNC(g_sync),
      .LIGHT_SOURCE_SELECT0(l0), .LIGHT_SOURCE_SELECT1(l1),
      .MIRROR_ARRAY_DRIVE_ENABLE_N(men),
      .TEST_POINT_PINS_I(t_pin), .TEST_POINT_PINS_O(t_o), .TEST_POINT_PINS_OE(t_oe),
      .TEST_MODE_SELECT(tms), .CONFIG_START(cfg_start), .CONFIG_ACTIVE(cfg_act),
      .I2C_QUIET_DONE(qdone));

   dcr_host_model u_host (
      .clk(clk), .go(go), .park_late(park_late), .strap(strap),
      .poc_n(poc_n), .park_n(park_n), .test_o(t_o), .test_oe(t_oe), .test_pin(t_pin));

   // free-running 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // verdict in one place, for both normal end and hang
   task automatic report_and_stop();
      if (bad_count == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // fresh random core values each enabled cycle, active levels included
   task automatic drive();
      {f_sck, f_sdo, f_cs0, f_cs1, f_l0, f_l1, f_men} = 7'($random(seed));
      f_gout = GW'($random(seed));
      f_goe  = GW'($random(seed));
      gpio_i = GW'($random(seed));
      f_tout = TW'($random(seed));
   endtask

   // expectations from the synchronised pin history, 3 edges to outputs
   task automatic check();
      logic act;
      act = hist[2];
      `CHK(cfg_act, act, "config active level")
      `CHK(cfg_start, hist[2] & ~hist[3], "config start pulse")
      `CHK(foe, act, "flash drive enable")
      `CHK(gp_oe, act ? f_goe : {GW{1'b0}}, "gpio drive enable")
      `CHK({l0, l1, men}, act ? {f_l0, f_l1, f_men} : 3'h0, "light and mirror pins")
      `CHK({cs0, cs1}, act ? {f_cs0, f_cs1} : 2'h3, "chip select rest level")
      if (act) `CHK({sck, sdo, gp_o}, {f_sck, f_sdo, f_gout}, "flash and gpio data")
      `CHK(t_oe, {TW{k >= 151}}, "test pin drive enable")
      `CHK(tms, (k >= 151) ? strap : {TW{1'b0}}, "test mode capture")
      if (k >= 151) `CHK(t_o, f_tout, "test pin output data")
      `CHK(qdone, bc >= QUIET, "two-wire quiet status")
      `CHK(g_sync, g2, "gpio input synchroniser")
   endtask

   // one cycle: track the pins at the rising edge, compare and drive at the falling
   task automatic tick();
      @(posedge clk);
      if (rst)
      begin
         hist = 4'h0;
         ph   = 3'h0;
         k    = 0;
         bc   = 0;
         g1   = '0;
         g2   = '0;
      end
      else if (ce)
      begin
         // a disabled edge moves nothing, in the model as in the block
         hist = {hist[2:0], poc_n};
         ph   = {ph[1:0], park_n};
         k    = hist[2] ? k + 1 : 0;
         bc   = (hist[2] & ph[2]) ? bc + 1 : 0;
         g2   = g1;
         g1   = gpio_i;
      end
      @(negedge clk);
      check();
      // inputs stay put ahead of a frozen edge, so held outputs still match
      ce = ce_plan;
      if (ce)
         drive();
   endtask

   // rounds: all-low and all-high straps, late park, frozen enable, reset in mid-run
   initial
   begin
      seed      = 65;
      bad_count = 0;
      tests_run = 0;
      rst       = 1'b1;
      go        = 1'b0;
      park_late = 1'b0;
      strap     = '0;
      hist      = 4'h0;
      ph        = 3'h0;
      ce        = 1'b1;
      ce_plan   = 1'b1;
      k         = 0;
      bc        = 0;
      g1        = '0;
      g2        = '0;
      drive();
      repeat (2) @(negedge clk);
      rst = 1'b0;
      for (int r = 0; r < 6; r++)
      begin
         park_late <= (r == 2);
         go        <= 1'b0;
         repeat (4 + ($unsigned($random(seed)) % 8)) tick();
         // new straps only once the previous capture has been cleared
         strap     = (r == 0) ? {TW{1'b0}} : (r == 1) ? {TW{1'b1}} : TW'($random(seed));
         go <= 1'b1;
         for (int c = 0; c < 200; c++)
         begin
            rst     = (r == 4) && (c >= 60) && (c < 62);
            // round 3 freezes the block for some edges during the sample delay
            ce_plan = !((r == 3) && (c >= 80) && (c < 96) && (c % 4 != 0));
            tick();
         end
      end
      report_and_stop();
   end

   // hang guard, a little beyond the longest expected run
   initial
   begin
      repeat (1600) @(posedge clk);
      bad_count++;
      report_and_stop();
   end
endmodule
`default_nettype wire
